// ==== src/gfd_angle_cmp.sv ====
`timescale 1ns/1ps
module gfd_angle_cmp
   import gfd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   gfd_cmp_if.cmp bus
);
   wire signed [36:0] rx = 37'(bus.op_re) * bus.rc - 37'(bus.op_im) * bus.rs;
   wire signed [36:0] ry = 37'(bus.op_re) * bus.rs + 37'(bus.op_im) * bus.rc;
   wire signed [21:0] orr = 22'(rx >>> QF);
   wire signed [21:0] ori = 22'(ry >>> QF);
   wire signed [44:0] dot = 45'(orr) * bus.pol_re + 45'(ori) * bus.pol_im;
   wire signed [45:0] mo = 46'(orr) * orr + 46'(ori) * ori;
   wire signed [45:0] mp = 46'(bus.pol_re) * bus.pol_re + 46'(bus.pol_im) * bus.pol_im;
   wire signed [119:0] lhs = (120'(dot) * dot) <<< (2 * QF);
   wire [119:0] mm = 120'(mo) * mp;
   wire [119:0] rf = mm * bus.fl * bus.fl;
   wire [119:0] rr = mm * bus.rl * bus.rl;
   // The forward limit (fl) and the reverse limit (rl) each bound their own zone on both sides of the rotated reference.
   wire fwd_next = (dot > 0) && ($unsigned(lhs) >= rf);
   wire rev_next = (dot < 0) && ($unsigned(lhs) >= rr);
   logic fwd_reg;
   logic rev_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fwd_reg <= 1'b0;
         rev_reg <= 1'b0;
      end
      else
      begin
         fwd_reg <= fwd_next;
         rev_reg <= rev_next;
      end
   end

   assign bus.fwd = fwd_reg;
   assign bus.rev = rev_reg;

   cmp_excl_a: assert property (@(posedge aclk) disable iff (!aresetn) !(fwd_reg && rev_reg))
      else $error("Comparator shows both directions.");
   cmp_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn) fwd_reg |-> $past(dot) > 0)
      else $error("Forward without positive projection.");
endmodule

// ==== src/gfd_cmp_if.sv ====
`timescale 1ns/1ps
interface gfd_cmp_if;
   import gfd_pkg::*;
   logic signed [PW-1:0] op_re, op_im, pol_re, pol_im;
   logic signed [15:0] rc, rs;
   logic [15:0] fl, rl;
   logic fwd, rev;
   modport src (output op_re, op_im, pol_re, pol_im, rc, rs, fl, rl, input fwd, rev);
   modport cmp (input op_re, op_im, pol_re, pol_im, rc, rs, fl, rl, output fwd, rev);
endinterface

// ==== src/gfd_dir_unit.sv ====
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module gfd_dir_unit
   import gfd_pkg::*;
#(
   parameter int unsigned REV_PERSIST = REV_PERSIST_CYC,
   parameter int unsigned FWD_DELAY = FWD_DELAY_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic signed [15:0] v0_re,
   input wire logic signed [15:0] v0_im,
   input wire logic [15:0] v0_mag,
   input wire logic signed [15:0] auxiliary_voltage_input_re,
   input wire logic signed [15:0] auxiliary_voltage_input_im,
   input wire logic [15:0] auxiliary_voltage_input_mag,
   input wire logic signed [15:0] i0_re,
   input wire logic signed [15:0] i0_im,
   input wire logic [15:0] i0_mag,
   input wire logic [15:0] i1_mag,
   input wire logic signed [15:0] measured_ground_current_re,
   input wire logic signed [15:0] measured_ground_current_im,
   input wire logic [15:0] measured_ground_current_mag,
   input wire logic block_in,
   output logic forward_fault_output,
   output logic reverse_fault_output,
   output logic irq
);
   logic [5:0] ctrl_reg;
   logic [14:0] zoff_reg;
   logic [31:0] ang_reg;
   logic [31:0] lim_reg;
   logic [15:0] fpk_reg;
   logic [15:0] rpk_reg;
   logic [1:0] istat_reg;
   logic [1:0] imask_reg;
   logic irq_reg;
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic v_ok_reg;
   logic g_ok_reg;
   logic [17:0] iop_reg;
   logic [CNT_W-1:0] rcnt_reg;
   logic [CNT_W-1:0] fcnt_reg;
   logic armed_reg;
   logic fwd_reg;
   logic rev_reg;

   gfd_cmp_if vc ();
   gfd_cmp_if cc ();

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            r[8*b+:8] = d[8*b+:8];
         end
      end
      return r;
   endfunction

   // Settings decode.
   wire op_gnd = ctrl_reg[C_OPSEL];
   wire aux_sel = ctrl_reg[C_VSEL];
   wire [1:0] mode_raw = ctrl_reg[C_MODE+:2];
   wire run = ctrl_reg[C_EN] & ~ctrl_reg[C_BLK] & ~block_in;
   // Ground operating current allows only voltage polarizing.
   gfd_pol_e mode;
   assign mode = (op_gnd || mode_raw == 2'b11) ? POL_VOLT : gfd_pol_e'(mode_raw);

   // Polarizing voltage selection.
   wire signed [15:0] aux_re3 = auxiliary_voltage_input_re / 16'sd3;
   wire signed [15:0] aux_im3 = auxiliary_voltage_input_im / 16'sd3;
   wire [15:0] aux_mag3 = auxiliary_voltage_input_mag / 16'd3;
   wire signed [15:0] pv_re = aux_sel ? aux_re3 : v0_re;
   wire signed [15:0] pv_im = aux_sel ? aux_im3 : v0_im;
   wire [15:0] pv_mag = aux_sel ? aux_mag3 : v0_mag;

   // Operating current and offset term.
   wire signed [15:0] g3_re = measured_ground_current_re / 16'sd3;
   wire signed [15:0] g3_im = measured_ground_current_im / 16'sd3;
   wire signed [15:0] oi_re = op_gnd ? g3_re : i0_re;
   wire signed [15:0] oi_im = op_gnd ? g3_im : i0_im;
   wire signed [15:0] op_re = op_gnd ? measured_ground_current_re : i0_re;
   wire signed [15:0] op_im = op_gnd ? measured_ground_current_im : i0_im;
   wire signed [31:0] zi_re = $signed({1'b0, zoff_reg}) * oi_re;
   wire signed [31:0] zi_im = $signed({1'b0, zoff_reg}) * oi_im;

   // Voltage comparator: reference is the characteristic angle.
   assign vc.op_re = PW'(op_re);
   assign vc.op_im = PW'(op_im);
   assign vc.pol_re = PW'(zi_re >>> ZSH) - PW'(pv_re);
   assign vc.pol_im = PW'(zi_im >>> ZSH) - PW'(pv_im);
   assign vc.rc = ang_reg[15:0];
   assign vc.rs = ang_reg[31:16];
   assign vc.fl = lim_reg[15:0];
   assign vc.rl = lim_reg[31:16];

   // Current comparator: ground current reference, fixed zero angle.
   assign cc.op_re = PW'(i0_re);
   assign cc.op_im = PW'(i0_im);
   assign cc.pol_re = PW'(measured_ground_current_re);
   assign cc.pol_im = PW'(measured_ground_current_im);
   assign cc.rc = Q_ONE;
   assign cc.rs = 16'sh0000;
   assign cc.fl = lim_reg[15:0];
   assign cc.rl = lim_reg[31:16];

   gfd_angle_cmp u_vcmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(vc.cmp)
   );

   gfd_angle_cmp u_ccmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(cc.cmp)
   );

   // Operating magnitude: positive-sequence restraint applies to the zero-sequence current only.
   wire [17:0] i0x3 = 18'(i0_mag) * 18'd3;
   wire [17:0] i1x3 = 18'(i1_mag) * 18'd3;
   wire [17:0] i1r = i1x3 >> 4;
   wire [17:0] iop_calc = (i0x3 > i1r) ? i0x3 - i1r : 18'h00000;
   wire [17:0] iop = op_gnd ? 18'(measured_ground_current_mag) : iop_calc;

   // Direction combining.
   wire vf = vc.fwd & v_ok_reg;
   wire vr = vc.rev & v_ok_reg;
   wire cf = cc.fwd & g_ok_reg;
   wire cr = cc.rev & g_ok_reg;
   wire raw_f = (mode == POL_VOLT) ? vf : (mode == POL_CUR) ? cf : (vf | cf);
   wire raw_r = (mode == POL_VOLT) ? vr : (mode == POL_CUR) ? cr : (vr | cr);
   wire dir_f = raw_f;
   wire dir_r = raw_r & ~raw_f;

   // Current reversal timing.
   wire [CNT_W-1:0] rev_lim = CNT_W'(REV_PERSIST);
   wire [CNT_W-1:0] fwd_lim = CNT_W'(FWD_DELAY);
   wire fwd_ok = ~armed_reg | (fcnt_reg >= fwd_lim);
   wire [CNT_W-1:0] rcnt_next = (!run || !dir_r) ? '0 : (rcnt_reg < rev_lim) ? rcnt_reg + 1'b1 : rcnt_reg;
   wire [CNT_W-1:0] fcnt_next = (!run || !dir_f || !armed_reg) ? '0 : (fcnt_reg < fwd_lim) ? fcnt_reg + 1'b1 : fcnt_reg;
   wire armed_next = run & ((armed_reg & ~(dir_f & fwd_ok)) | (rcnt_reg == rev_lim));
   wire fwd_next = run & dir_f & fwd_ok & (iop_reg > 18'(fpk_reg));
   wire rev_next = run & dir_r & (iop_reg > 18'(rpk_reg));

   // Bus write path.
   wire aw_take = awvalid & awready_reg;
   wire w_take = wvalid & wready_reg;
   wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire aw_full_next = (aw_full_reg | aw_take) & ~do_wr;
   wire w_full_next = (w_full_reg | w_take) & ~do_wr;
   wire bvalid_next = do_wr | (bvalid_reg & ~bready);
   wire [7:0] wa = {aw_addr_reg[7:2], 2'b00};
   wire wr_hit = (wa <= A_IMASK);
   wire [31:0] wm_ctrl = merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg);
   wire [31:0] wm_zoff = merge({17'h0, zoff_reg}, w_data_reg, w_strb_reg);
   wire [31:0] wm_ang = merge(ang_reg, w_data_reg, w_strb_reg);
   wire [31:0] wm_lim = merge(lim_reg, w_data_reg, w_strb_reg);
   wire [31:0] wm_fpk = merge({16'h0, fpk_reg}, w_data_reg, w_strb_reg);
   wire [31:0] wm_rpk = merge({16'h0, rpk_reg}, w_data_reg, w_strb_reg);
   wire [1:0] w1c = (do_wr && wa == A_ISTAT && w_strb_reg[0]) ? w_data_reg[1:0] : 2'b00;
   wire [1:0] events = {rev_next & ~rev_reg, fwd_next & ~fwd_reg};
   // A new event wins over a clear in the same cycle.
   wire [1:0] istat_next = (istat_reg & ~w1c) | events;

   // Bus read path.
   wire ar_take = arvalid & arready_reg;
   wire rvalid_next = ar_take | (rvalid_reg & ~rready);
   wire [7:0] ra = {araddr[7:2], 2'b00};
   wire rd_hit = (ra <= A_IMASK);
   wire [31:0] status = {2'h0, iop_reg[17:2], 9'h000, armed_reg, g_ok_reg, v_ok_reg, rev_reg, fwd_reg};
   wire [31:0] rd_mux =
      (ra == A_CTRL) ? {26'h0, ctrl_reg} :
      (ra == A_ZOFF) ? {17'h0, zoff_reg} :
      (ra == A_ANG) ? ang_reg :
      (ra == A_LIM) ? lim_reg :
      (ra == A_FPK) ? {16'h0, fpk_reg} :
      (ra == A_RPK) ? {16'h0, rpk_reg} :
      (ra == A_STAT) ? status :
      (ra == A_ISTAT) ? {30'h0, istat_reg} :
      (ra == A_IMASK) ? {30'h0, imask_reg} : 32'h0000_0000;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OK;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_addr_reg <= aw_take ? awaddr : aw_addr_reg;
         w_data_reg <= w_take ? wdata : w_data_reg;
         w_strb_reg <= w_take ? wstrb : w_strb_reg;
         awready_reg <= ~aw_full_next;
         wready_reg <= ~w_full_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= do_wr ? (wr_hit ? RESP_OK : RESP_ERR) : bresp_reg;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OK;
      end
      else
      begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= ar_take ? rd_mux : rdata_reg;
         rresp_reg <= ar_take ? (rd_hit ? RESP_OK : RESP_ERR) : rresp_reg;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= CTRL_RST;
         zoff_reg <= ZOFF_RST;
         ang_reg <= ANG_RST;
         lim_reg <= LIM_RST;
         fpk_reg <= PICK_RST;
         rpk_reg <= PICK_RST;
         imask_reg <= 2'b00;
      end
      else if (do_wr)
      begin
         ctrl_reg <= (wa == A_CTRL) ? wm_ctrl[5:0] : ctrl_reg;
         zoff_reg <= (wa == A_ZOFF) ? wm_zoff[14:0] : zoff_reg;
         ang_reg <= (wa == A_ANG) ? wm_ang : ang_reg;
         lim_reg <= (wa == A_LIM) ? wm_lim : lim_reg;
         fpk_reg <= (wa == A_FPK) ? wm_fpk[15:0] : fpk_reg;
         rpk_reg <= (wa == A_RPK) ? wm_rpk[15:0] : rpk_reg;
         imask_reg <= (wa == A_IMASK && w_strb_reg[0]) ? w_data_reg[1:0] : imask_reg;
      end
   end

   // Protection pipeline: validity and magnitude align with comparator outputs.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         v_ok_reg <= 1'b0;
         g_ok_reg <= 1'b0;
         iop_reg <= 18'h00000;
         rcnt_reg <= '0;
         fcnt_reg <= '0;
         armed_reg <= 1'b0;
         fwd_reg <= 1'b0;
         rev_reg <= 1'b0;
         istat_reg <= 2'b00;
         irq_reg <= 1'b0;
      end
      else
      begin
         v_ok_reg <= pv_mag > V_MIN;
         g_ok_reg <= measured_ground_current_mag > G_MIN;
         iop_reg <= iop;
         rcnt_reg <= rcnt_next;
         fcnt_reg <= fcnt_next;
         armed_reg <= armed_next;
         fwd_reg <= fwd_next;
         rev_reg <= rev_next;
         istat_reg <= istat_next;
         irq_reg <= |(istat_reg & imask_reg);
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign forward_fault_output = fwd_reg;
   assign reverse_fault_output = rev_reg;
   assign irq = irq_reg;

   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence halt_s;
      !run;
   endsequence
   sequence quiet_s;
      !fwd_reg && !rev_reg && rcnt_reg == '0 && !armed_reg;
   endsequence

   halt_clear_a: assert property (halt_s |=> quiet_s)
      else $error("Outputs or reversal timing not cleared while halted.");
   v_invalid_a: assert property (mode == POL_VOLT && !v_ok_reg |=> !fwd_reg && !rev_reg)
      else $error("Indication with invalid polarizing voltage.");
   g_invalid_a: assert property (mode == POL_CUR && !g_ok_reg |=> !fwd_reg && !rev_reg)
      else $error("Indication with invalid polarizing current.");
   fwd_wins_a: assert property (raw_f && raw_r |=> !rev_reg)
      else $error("Reverse not suppressed on conflict.");
   fwd_pick_a: assert property (fwd_reg |-> $past(iop_reg) > 18'($past(fpk_reg)) && $past(dir_f))
      else $error("Forward output without pickup and direction.");
   rev_pick_a: assert property (rev_reg |-> $past(iop_reg) > 18'($past(rpk_reg)) && $past(dir_r))
      else $error("Reverse output without pickup and direction.");
   fwd_hold_a: assert property ($rose(fwd_reg) |-> !$past(armed_reg) || $past(fcnt_reg) >= fwd_lim)
      else $error("Forward released before reversal delay.");
   gnd_volt_a: assert property (op_gnd |-> mode == POL_VOLT)
      else $error("Ground operating current without voltage polarizing.");
   irq_level_a: assert property (irq_reg == |($past(istat_reg) & $past(imask_reg)))
      else $error("Interrupt level does not follow masked status.");
endmodule

// ==== src/gfd_pkg.sv ====
package gfd_pkg;
   // Timing.
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned PCYC_NS = 16_666_667;
   localparam int unsigned REV_PERSIST_NS = PCYC_NS * 5 / 4;
   localparam int unsigned FWD_DELAY_NS = PCYC_NS * 3 / 2;
   localparam int unsigned REV_PERSIST_CYC = (REV_PERSIST_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned FWD_DELAY_CYC = (FWD_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 20;
   // Arithmetic formats.
   localparam int PW = 20;
   localparam int QF = 14;
   localparam int ZSH = 12;
   localparam logic [15:0] V_MIN = 16'h0014;
   localparam logic [15:0] G_MIN = 16'h0032;
   localparam logic signed [15:0] Q_ONE = 16'sh4000;
   // Register byte addresses.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ZOFF = 8'h04;
   localparam logic [7:0] A_ANG = 8'h08;
   localparam logic [7:0] A_LIM = 8'h0C;
   localparam logic [7:0] A_FPK = 8'h10;
   localparam logic [7:0] A_RPK = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_ISTAT = 8'h1C;
   localparam logic [7:0] A_IMASK = 8'h20;
   // Control field positions.
   localparam int C_EN = 0;
   localparam int C_BLK = 1;
   localparam int C_MODE = 2;
   localparam int C_VSEL = 4;
   localparam int C_OPSEL = 5;
   // Values after reset.
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [14:0] ZOFF_RST = 15'h0000;
   localparam logic [31:0] ANG_RST = 32'h3DD2_1090;
   localparam logic [31:0] LIM_RST = 32'h0000_0000;
   localparam logic [15:0] PICK_RST = 16'h0032;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [1:0] {
      POL_VOLT = 2'b00,
      POL_CUR = 2'b01,
      POL_DUAL = 2'b10
   } gfd_pol_e;
endpackage

// ==== testbench/gfd_front_model.sv ====
`timescale 1ns/1ps
module gfd_front_model
(
   output logic signed [15:0] v_re,
   output logic [15:0] v_mag,
   output logic signed [15:0] a_re,
   output logic [15:0] a_mag,
   output logic signed [15:0] i_re,
   output logic signed [15:0] i_im,
   output logic [15:0] i_mag,
   output logic [15:0] p_mag,
   output logic signed [15:0] g_re,
   output logic [15:0] g_mag
);
   // Only the current phasor has an imaginary part, and each magnitude is the sum of the absolute values of its parts.
   logic signed [15:0] ph [6] = '{default: 16'sh0000};
   function automatic logic [15:0] mag(input logic signed [15:0] x);
      return x < 0 ? -x : x;
   endfunction
   task automatic set_ph(input int v, input int a, input int i, input int p, input int g);
      ph[0] <= 16'(v);
      ph[1] <= 16'(a);
      ph[2] <= 16'(i);
      ph[3] <= 16'(p);
      ph[4] <= 16'(g);
   endtask
   task automatic set_im(input int i);
      ph[5] <= 16'(i);
   endtask
   assign v_re = ph[0];
   assign v_mag = mag(ph[0]);
   assign a_re = ph[1];
   assign a_mag = mag(ph[1]);
   assign i_re = ph[2];
   assign i_im = ph[5];
   assign i_mag = mag(ph[2]) + mag(ph[5]);
   assign p_mag = mag(ph[3]);
   assign g_re = ph[4];
   assign g_mag = mag(ph[4]);
endmodule

// ==== testbench/tb_ground_fault_direction_unit.sv ====
`timescale 1ns/1ps
module tb_ground_fault_direction_unit;
   import gfd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, block_in = 1'b0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, fwd, rev, irq;
   logic [1:0] bresp, rresp;
   logic signed [15:0] v_re, a_re, i_re, i_im, g_re;
   logic [15:0] v_mag, a_mag, i_mag, p_mag, g_mag;
   int n_mismatch = 0;
   int n_checks = 0;
   initial forever #50 aclk = ~aclk;
   gfd_front_model fe_u (.v_re(v_re), .v_mag(v_mag), .a_re(a_re), .a_mag(a_mag), .i_re(i_re),
      .i_im(i_im), .i_mag(i_mag), .p_mag(p_mag), .g_re(g_re), .g_mag(g_mag));
   gfd_dir_unit #(.REV_PERSIST(10), .FWD_DELAY(15)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .v0_re(v_re), .v0_im(16'sh0000), .v0_mag(v_mag),
      .auxiliary_voltage_input_re(a_re), .auxiliary_voltage_input_im(16'sh0000),
      .auxiliary_voltage_input_mag(a_mag), .i0_re(i_re), .i0_im(i_im), .i0_mag(i_mag),
      .i1_mag(p_mag), .measured_ground_current_re(g_re), .measured_ground_current_im(16'sh0000),
      .measured_ground_current_mag(g_mag), .block_in(block_in), .forward_fault_output(fwd),
      .reverse_fault_output(rev), .irq(irq));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK,
      input logic [3:0] s = 4'hF);
      logic ta, tw, bv;
      bv = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bv)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         bv = bvalid;
         if (bv)
            chk("bresp", 32'(er), 32'(bresp));
         @(posedge aclk);
         awvalid <= awvalid & ~ta;
         wvalid <= wvalid & ~tw;
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OK);
      logic ta, rv;
      rv = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rv)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         rv = rvalid;
         if (rv)
         begin
            chk("rdata", ed, rdata);
            chk("rresp", 32'(er), 32'(rresp));
         end
         @(posedge aclk);
         arvalid <= arvalid & ~ta;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic out(input logic f, input logic r, input int n = 4);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
      chk("forward", 32'(f), 32'(fwd));
      chk("reverse", 32'(r), 32'(rev));
      @(posedge aclk);
   endtask
   task automatic irq_is(input logic e);
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk("irq", 32'(e), 32'(irq));
      @(posedge aclk);
   endtask
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      end_sim;
   end
   initial
   begin
      fe_u.set_ph(-1000, 0, 1000, 0, 0);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_ANG, ANG_RST);
      rd(A_FPK, 32'(PICK_RST));
      rd(8'h24, 32'h0000_0000, RESP_ERR);
      wr(8'h24, 32'hFFFF_FFFF, RESP_ERR);
      rd(A_CTRL, 32'h0000_0000);
      wr(A_ZOFF, 32'h0000_7F00, RESP_OK, 4'h1);
      rd(A_ZOFF, 32'h0000_0000);
      out(0, 0);
      $display("test reset done");
      wr(A_ANG, 32'h0000_4000);
      wr(A_CTRL, 32'h0000_0001);
      out(1, 0);
      irq_is(0);
      rd(A_ISTAT, 32'h0000_0001);
      wr(A_IMASK, 32'h0000_0001);
      irq_is(1);
      wr(A_ISTAT, 32'h0000_0001);
      irq_is(0);
      block_in <= 1'b1;
      out(0, 0);
      block_in <= 1'b0;
      out(1, 0);
      wr(A_CTRL, 32'h0000_0003);
      out(0, 0);
      wr(A_CTRL, 32'h0000_0001);
      $display("test enable and irq done");
      fe_u.set_ph(-1000, 0, 100, 320, 0);
      wr(A_FPK, 32'h0000_00F0);
      out(0, 0);
      wr(A_FPK, 32'h0000_00EF);
      out(1, 0);
      wr(A_FPK, 32'h0000_0032);
      fe_u.set_ph(-20, 0, 1000, 0, 0);
      out(0, 0);
      fe_u.set_ph(-21, 0, 1000, 0, 0);
      out(1, 0);
      wr(A_ZOFF, 32'h0000_2000);
      fe_u.set_ph(100, 0, 1000, 0, 0);
      out(1, 0);
      $display("test pickup and offset done");
      fe_u.set_ph(0, -60, 1000, 0, 0);
      wr(A_ZOFF, 32'h0000_0000);
      wr(A_CTRL, 32'h0000_0011);
      out(0, 0);
      fe_u.set_ph(0, -63, 1000, 0, 0);
      out(1, 0);
      wr(A_ANG, 32'h4000_0000);
      wr(A_CTRL, 32'h0000_0005);
      fe_u.set_ph(0, 0, 1000, 0, 50);
      out(0, 0);
      fe_u.set_ph(0, 0, 1000, 0, 51);
      out(1, 0);
      wr(A_ANG, 32'h0000_4000);
      $display("test polarizing sources done");
      wr(A_CTRL, 32'h0000_0009);
      fe_u.set_ph(-1000, 0, 1000, 0, 0);
      out(1, 0);
      fe_u.set_ph(1000, 0, 1000, 0, 1000);
      out(1, 0);
      wr(A_CTRL, 32'h0000_0000);
      fe_u.set_ph(-1000, 0, 0, 0, 100);
      wr(A_FPK, 32'h0000_0063);
      wr(A_CTRL, 32'h0000_0025);
      out(1, 0);
      wr(A_FPK, 32'h0000_0064);
      out(0, 0);
      wr(A_FPK, 32'h0000_0032);
      wr(A_CTRL, 32'h0000_000D);
      wr(A_ANG, 32'h4000_0000);
      fe_u.set_ph(-1000, 0, 0, 0, 0);
      fe_u.set_im(-1000);
      out(1, 0);
      fe_u.set_im(0);
      wr(A_ANG, 32'h0000_4000);
      $display("test dual and ground done");
      wr(A_CTRL, 32'h0000_0001);
      wr(A_RPK, 32'h0000_0BB8);
      fe_u.set_ph(1000, 0, 1000, 0, 0);
      out(0, 0);
      wr(A_RPK, 32'h0000_0BB7);
      out(0, 1);
      rd(A_STAT, 32'h00BB_8016);
      fe_u.set_ph(-1000, 0, 1000, 0, 0);
      out(0, 0, 15);
      out(1, 0, 1);
      fe_u.set_ph(1000, 0, 1000, 0, 0);
      out(0, 1, 12);
      block_in <= 1'b1;
      @(posedge aclk);
      block_in <= 1'b0;
      fe_u.set_ph(-1000, 0, 1000, 0, 0);
      out(1, 0);
      $display("test reversal done");
      end_sim;
   end
endmodule
